// ===== inc/rmcs_map.svh
// Purpose: Offsets, field positions, reset values and counts of the RMII control block
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef RMCS_MAP_SVH
`define RMCS_MAP_SVH

`define RMCS_ADDR_W 5
`define RMCS_DW 16
`define RMCS_CTL_OFF 5'h17
`define RMCS_LED_OFF 5'h18
`define RMCS_CTL_RST 16'h0001
`define RMCS_LED_RST 16'h0400
`define RMCS_LED_WMASK 16'h0692
`define RMCS_TXSHIFT_BIT 8
`define RMCS_CLKSEL_BIT 7
`define RMCS_REVSEL_BIT 4
`define RMCS_OVF_BIT 3
`define RMCS_UNF_BIT 2
`define RMCS_ELAS_MSB 1
`define RMCS_ELAS_LSB 0
`define RMCS_PW 5
`define RMCS_AW 4
`define RMCS_DEPTH 16
`define RMCS_THR_14B 5'h07
`define RMCS_THR_2B 5'h01
`define RMCS_THR_6B 5'h03
`define RMCS_THR_10B 5'h05

`endif

// ===== inc/rmcs_pkg.sv
// Purpose: Types shared by the RMII control block
// Assumes: Nothing
// Notes: Numbers live in rmcs_map.svh
`default_nettype none

package rmcs_pkg;

	typedef enum logic [1:0] {
		rmcs_st_idle = 2'b00,
		rmcs_st_fill = 2'b01,
		rmcs_st_run = 2'b10
	} rmcs_rd_state_t;

	typedef enum logic [1:0] {
		rmcs_tol_14b = 2'b00,
		rmcs_tol_2b = 2'b01,
		rmcs_tol_6b = 2'b10,
		rmcs_tol_10b = 2'b11
	} rmcs_elas_t;

endpackage : rmcs_pkg

`default_nettype wire

// ===== design/rmcs_sync2.sv
// Purpose: Two-flop synchroniser, one chain per bit
// Assumes: Multi-bit inputs are gray coded or quasi-static
// Notes: No reset, so it can also carry the reset itself
`default_nettype none

module rmcs_sync2 #(
	parameter int W = 1
) (
	// Destination clock
	input wire logic clk,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_reg;
			logic sync_reg;
			always_ff @(posedge clk) begin
				meta_reg <= d[i];
				sync_reg <= meta_reg;
			end
			assign q[i] = sync_reg;
		end
	endgenerate

endmodule : rmcs_sync2

`default_nettype wire

// ===== design/rmcs_regs.sv
// Purpose: RMII control/status registers and receive elasticity buffer toward the MAC
// Assumes: Recovered dibits arrive as strobes on sys_clk; rmii_clk is the 50 MHz interface clock
// Notes: Management port is a simple parallel strobe port, read data one cycle late
`default_nettype none
`include "rmcs_map.svh"

module rmcs_regs (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Master/slave strap pin, high for master
	input wire logic strap_master,
	// Management register port
	input wire logic [`RMCS_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`RMCS_DW-1:0] reg_wdata,
	output logic [`RMCS_DW-1:0] reg_rdata,
	// Recovered receive stream
	input wire logic rx_valid,
	input wire logic [1:0] rx_dibit,
	input wire logic rx_carrier,
	// RMII receive side toward the MAC
	input wire logic rmii_clk,
	output logic crs_dv,
	output logic [1:0] rxd,
	// Clocking control
	output logic slave_mode,
	output logic ref_clk_50m_sel,
	output logic tx_clk_shift_en
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic strap_s;
	logic strap_taken_reg;
	logic slave_reg;
	logic tx_shift_reg;
	logic clk_sel_reg;
	logic rev_sel_reg;
	rmcs_pkg::rmcs_elas_t elas_reg;
	logic ovf_seen_reg;
	logic unf_seen_reg;
	logic [`RMCS_DW-1:0] led_reg;
	logic [`RMCS_DW-1:0] rdata_reg;
	logic [`RMCS_DW-1:0] ctl_val;
	logic tx_shift_en_reg;
	logic ctl_hit;
	logic led_hit;
	// Named copy so reset fields can be selected; a literal cannot be indexed
	localparam logic [`RMCS_DW-1:0] ctl_rst_val = `RMCS_CTL_RST;

	logic [1:0] mem_reg [0:`RMCS_DEPTH-1];
	logic [`RMCS_PW-1:0] wbin_reg;
	logic [`RMCS_PW-1:0] wgray_reg;
	logic [`RMCS_PW-1:0] rgray_s;
	logic full;
	logic ovf_evt;
	logic unf_s;
	logic unf_d_reg;
	logic unf_evt;

	logic link_rst;
	logic car_s;
	logic rev_s;
	logic [1:0] elas_s;
	logic [`RMCS_PW-1:0] wgray_s;
	logic [`RMCS_PW-1:0] wbin_s;
	logic [`RMCS_PW-1:0] rbin_reg;
	logic [`RMCS_PW-1:0] rgray_reg;
	logic [`RMCS_PW-1:0] fill;
	logic [`RMCS_PW-1:0] thr;
	logic empty;
	rmcs_pkg::rmcs_rd_state_t st_reg;
	logic crs_dv_reg;
	logic [1:0] rxd_reg;
	logic unf_tgl_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [`RMCS_PW-1:0] gray_to_bin(input logic [`RMCS_PW-1:0] g);
		logic [`RMCS_PW-1:0] b;
		b = '0;
		b[`RMCS_PW-1] = g[`RMCS_PW-1];
		for (int k = `RMCS_PW - 2; k >= 0; k--) begin
			b[k] = b[k+1] ^ g[k];
		end
		return b;
	endfunction : gray_to_bin

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture

	rmcs_sync2 #(.W(1)) u_strap_sync (
		.clk(sys_clk),
		.d(strap_master),
		.q(strap_s)
	);

	// Strap is taken on the first edge after release, never under reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			strap_taken_reg <= 1'b0;
			slave_reg <= 1'b0;
		end else if (!strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			slave_reg <= ~strap_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register decode and writes

	always_comb begin
		ctl_hit = 1'b0;
		led_hit = 1'b0;
		if (reg_addr == `RMCS_CTL_OFF) begin
			ctl_hit = 1'b1;
		end else if (reg_addr == `RMCS_LED_OFF) begin
			led_hit = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_shift_reg <= ctl_rst_val[`RMCS_TXSHIFT_BIT];
			rev_sel_reg <= ctl_rst_val[`RMCS_REVSEL_BIT];
			elas_reg <= rmcs_pkg::rmcs_elas_t'(ctl_rst_val[`RMCS_ELAS_MSB:`RMCS_ELAS_LSB]);
		end else if (reg_wr && ctl_hit) begin
			tx_shift_reg <= reg_wdata[`RMCS_TXSHIFT_BIT];
			rev_sel_reg <= reg_wdata[`RMCS_REVSEL_BIT];
			elas_reg <= rmcs_pkg::rmcs_elas_t'(reg_wdata[`RMCS_ELAS_MSB:`RMCS_ELAS_LSB]);
		end
	end

	// Strap default loads once; a write in that very cycle still wins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clk_sel_reg <= ctl_rst_val[`RMCS_CLKSEL_BIT];
		end else if (reg_wr && ctl_hit) begin
			clk_sel_reg <= reg_wdata[`RMCS_CLKSEL_BIT];
		end else if (!strap_taken_reg) begin
			clk_sel_reg <= ~strap_s;
		end
	end

	// Only the defined LED fields store; reserved bits stay zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			led_reg <= `RMCS_LED_RST;
		end else if (reg_wr && led_hit) begin
			led_reg <= reg_wdata & `RMCS_LED_WMASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags

	// Sticky detect flags, cleared by reading the register; a new event wins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ovf_seen_reg <= 1'b0;
		end else if (ovf_evt) begin
			ovf_seen_reg <= 1'b1;
		end else if (reg_rd && ctl_hit) begin
			ovf_seen_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			unf_seen_reg <= 1'b0;
		end else if (unf_evt) begin
			unf_seen_reg <= 1'b1;
		end else if (reg_rd && ctl_hit) begin
			unf_seen_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	always_comb begin
		ctl_val = '0;
		ctl_val[`RMCS_TXSHIFT_BIT] = tx_shift_reg;
		ctl_val[`RMCS_CLKSEL_BIT] = clk_sel_reg;
		ctl_val[`RMCS_REVSEL_BIT] = rev_sel_reg;
		ctl_val[`RMCS_OVF_BIT] = ~ovf_seen_reg;
		ctl_val[`RMCS_UNF_BIT] = ~unf_seen_reg;
		ctl_val[`RMCS_ELAS_MSB:`RMCS_ELAS_LSB] = elas_reg;
	end

	// Unmapped offsets read as zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_reg <= '0;
		end else if (reg_rd && ctl_hit) begin
			rdata_reg <= ctl_val;
		end else if (reg_rd && led_hit) begin
			rdata_reg <= led_reg;
		end else if (reg_rd) begin
			rdata_reg <= '0;
		end
	end

	assign reg_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Clocking control outputs

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_shift_en_reg <= 1'b0;
		end else begin
			tx_shift_en_reg <= tx_shift_reg && slave_reg;
		end
	end

	assign tx_clk_shift_en = tx_shift_en_reg;
	assign ref_clk_50m_sel = clk_sel_reg;
	assign slave_mode = slave_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Elasticity buffer, write side (sys_clk)

	rmcs_sync2 #(.W(`RMCS_PW)) u_rptr_sync (
		.clk(sys_clk),
		.d(rgray_reg),
		.q(rgray_s)
	);

	assign full = (wgray_reg == {~rgray_s[`RMCS_PW-1:`RMCS_PW-2], rgray_s[`RMCS_PW-3:0]});
	assign ovf_evt = rx_valid && full;

	// A dibit arriving when full is dropped and flagged
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
		end else if (rx_valid && !full) begin
			wbin_reg <= wbin_reg + 1'b1;
			wgray_reg <= (wbin_reg + 1'b1) ^ ((wbin_reg + 1'b1) >> 1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rx_valid && !full) begin
			mem_reg[wbin_reg[`RMCS_AW-1:0]] <= rx_dibit;
		end
	end

	// Underflow arrives as a toggle; edge taken after the second flop
	rmcs_sync2 #(.W(1)) u_unf_sync (
		.clk(sys_clk),
		.d(unf_tgl_reg),
		.q(unf_s)
	);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			unf_d_reg <= 1'b0;
		end else begin
			unf_d_reg <= unf_s;
		end
	end

	assign unf_evt = unf_s ^ unf_d_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain crossings (rmii_clk)

	rmcs_sync2 #(.W(1)) u_rst_sync (
		.clk(rmii_clk),
		.d(rst),
		.q(link_rst)
	);

	rmcs_sync2 #(.W(1)) u_car_sync (
		.clk(rmii_clk),
		.d(rx_carrier),
		.q(car_s)
	);

	// Config is quasi-static; change it only between packets
	rmcs_sync2 #(.W(3)) u_cfg_sync (
		.clk(rmii_clk),
		.d({rev_sel_reg, elas_reg}),
		.q({rev_s, elas_s})
	);

	rmcs_sync2 #(.W(`RMCS_PW)) u_wptr_sync (
		.clk(rmii_clk),
		.d(wgray_reg),
		.q(wgray_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Elasticity buffer, read side (rmii_clk)

	assign wbin_s = gray_to_bin(wgray_s);
	assign fill = wbin_s - rbin_reg;
	assign empty = (fill == '0);

	// Prefill of the whole tolerance, counted in dibits
	always_comb begin
		case (rmcs_pkg::rmcs_elas_t'(elas_s))
			rmcs_pkg::rmcs_tol_14b: thr = `RMCS_THR_14B;
			rmcs_pkg::rmcs_tol_2b: thr = `RMCS_THR_2B;
			rmcs_pkg::rmcs_tol_6b: thr = `RMCS_THR_6B;
			rmcs_pkg::rmcs_tol_10b: thr = `RMCS_THR_10B;
			default: thr = `RMCS_THR_2B;
		endcase
	end

	always_ff @(posedge rmii_clk) begin
		if (link_rst) begin
			st_reg <= rmcs_pkg::rmcs_st_idle;
		end else begin
			case (st_reg)
				rmcs_pkg::rmcs_st_idle: begin
					if (!empty) begin
						st_reg <= rmcs_pkg::rmcs_st_fill;
					end
				end
				rmcs_pkg::rmcs_st_fill: begin
					// Short tail of a packet must not wait for a full prefill
					if (fill >= thr || !car_s) begin
						st_reg <= rmcs_pkg::rmcs_st_run;
					end
				end
				rmcs_pkg::rmcs_st_run: begin
					if (empty && !car_s) begin
						st_reg <= rmcs_pkg::rmcs_st_idle;
					end
				end
				default: st_reg <= rmcs_pkg::rmcs_st_idle;
			endcase
		end
	end

	always_ff @(posedge rmii_clk) begin
		if (link_rst) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
		end else if (st_reg == rmcs_pkg::rmcs_st_run && !empty) begin
			rbin_reg <= rbin_reg + 1'b1;
			rgray_reg <= (rbin_reg + 1'b1) ^ ((rbin_reg + 1'b1) >> 1);
		end
	end

	always_ff @(posedge rmii_clk) begin
		if (link_rst) begin
			rxd_reg <= '0;
		end else if (st_reg == rmcs_pkg::rmcs_st_run && !empty) begin
			rxd_reg <= mem_reg[rbin_reg[`RMCS_AW-1:0]];
		end else begin
			rxd_reg <= '0;
		end
	end

	// CRS_DV: carrier while prefilling, then high until drained; after carrier loss it toggles instead when rev_s is low
	always_ff @(posedge rmii_clk) begin
		if (link_rst) begin
			crs_dv_reg <= 1'b0;
		end else begin
			case (st_reg)
				rmcs_pkg::rmcs_st_idle: crs_dv_reg <= 1'b0;
				rmcs_pkg::rmcs_st_fill: crs_dv_reg <= car_s;
				rmcs_pkg::rmcs_st_run: begin
					if (car_s) begin
						crs_dv_reg <= 1'b1;
					end else if (empty) begin
						crs_dv_reg <= 1'b0;
					end else if (rev_s) begin
						crs_dv_reg <= 1'b1;
					end else begin
						crs_dv_reg <= ~crs_dv_reg;
					end
				end
				default: crs_dv_reg <= 1'b0;
			endcase
		end
	end

	// Buffer ran dry while the line still carries the packet
	always_ff @(posedge rmii_clk) begin
		if (link_rst) begin
			unf_tgl_reg <= 1'b0;
		end else if (st_reg == rmcs_pkg::rmcs_st_run && empty && car_s) begin
			unf_tgl_reg <= ~unf_tgl_reg;
		end
	end

	assign crs_dv = crs_dv_reg;
	assign rxd = rxd_reg;

endmodule : rmcs_regs

`default_nettype wire

// ===== verification/rmcs_mac_model.sv
// Purpose: MAC side of the RMII receive pins
// Assumes: rmii_clk runs free, as the reference clock does
// Notes: Counts carrier rises and all-ones dibits per packet
`default_nettype none

module rmcs_mac_model (
	// Interface clock
	input wire logic rmii_clk,
	// Receive pins
	input wire logic crs_dv,
	input wire logic [1:0] rxd,
	// Bench control and counters
	input wire logic clr,
	output int rises,
	output int dibits
);
	timeunit 1ns;
	timeprecision 100ps;
	logic crs_dv_reg;
	always @(posedge rmii_clk) begin
		crs_dv_reg <= crs_dv;
		if (clr) begin
			rises <= 0;
			dibits <= 0;
		end else begin
			// Each rise after a low cycle is a toggle seen by the MAC
			if (crs_dv && !crs_dv_reg) begin
				rises <= rises + 1;
			end
			if (rxd == 2'h3) begin
				dibits <= dibits + 1;
			end
		end
	end
endmodule : rmcs_mac_model

`default_nettype wire

// ===== verification/rmcs_regs_asserts.sv
// Purpose: Port checks of the RMII control block
// Assumes: Bound to rmcs_regs
// Notes: Link check runs on rmii_clk
`default_nettype none

module rmcs_regs_asserts (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic rmii_clk,
	input wire logic rst,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// Link and control
	input wire logic crs_dv,
	input wire logic [1:0] rxd,
	input wire logic slave_mode,
	input wire logic ref_clk_50m_sel,
	input wire logic tx_clk_shift_en
);
	shift_slave_a: assert property (@(posedge sys_clk) disable iff (rst)
		tx_clk_shift_en |-> slave_mode) else $error("shift enable outside slave mode");
	shift_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == 5'h17 && slave_mode |-> ##2 tx_clk_shift_en == $past(reg_wdata[8], 2))
		else $error("shift enable not following its bit");
	clksel_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == 5'h17 |=> ref_clk_50m_sel == $past(reg_wdata[7]))
		else $error("clock select not following write");
	strap_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) && !$past(rst, 2) |-> $stable(slave_mode)) else $error("mode moved after reset");
	led_rsvd_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == 5'h18 |=> (reg_rdata & 16'hF96D) == 16'h0000)
		else $error("LED reserved bits set");
	ctl_rsvd_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == 5'h17 |=> reg_rdata[15:9] == 7'h00 && reg_rdata[6:5] == 2'h0)
		else $error("control reserved bits set");
	unmap_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr != 5'h17 && reg_addr != 5'h18 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without read");
	link_data_a: assert property (@(posedge rmii_clk) disable iff (rst)
		rxd != 2'h0 |-> crs_dv || $past(crs_dv)) else $error("data outside frame");
endmodule : rmcs_regs_asserts

bind rmcs_regs rmcs_regs_asserts rmcs_regs_asserts_i (.sys_clk(sys_clk), .rmii_clk(rmii_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.crs_dv(crs_dv), .rxd(rxd), .slave_mode(slave_mode), .ref_clk_50m_sel(ref_clk_50m_sel),
	.tx_clk_shift_en(tx_clk_shift_en));

`default_nettype wire

// ===== verification/test_rmii_config_status_regs.sv
// Purpose: Register and receive stream tests of the RMII control block
// Assumes: Inputs change on falling sys_clk
// Notes: Reset spans 20 link cycles so the link reset settles too
`default_nettype none
`include "rmcs_map.svh"

module test_rmii_config_status_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 0, rmii_clk = 0, rst = 1, strap_master = 1;
	logic [4:0] reg_addr = 5'h00;
	logic reg_wr = 0, reg_rd = 0, rx_valid = 0, rx_carrier = 0, clr = 0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [1:0] rx_dibit = 2'h3;
	logic [1:0] rxd;
	logic crs_dv, slave_mode, ref_clk_50m_sel, tx_clk_shift_en;
	// Bit 4 selects the revision, bits 1:0 the elasticity tolerance
	logic [4:0] pk [5] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h00};
	int rises, dibits, mismatches = 0, n_compared = 0;
	always #2 sys_clk = ~sys_clk;
	// Odd start offset keeps the two clocks out of phase
	initial begin
		#1.3;
		forever #40 rmii_clk = ~rmii_clk;
	end
	rmcs_regs rmcs_regs_i (.sys_clk(sys_clk), .rst(rst), .strap_master(strap_master), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
		.rx_dibit(rx_dibit), .rx_carrier(rx_carrier), .rmii_clk(rmii_clk), .crs_dv(crs_dv), .rxd(rxd),
		.slave_mode(slave_mode), .ref_clk_50m_sel(ref_clk_50m_sel), .tx_clk_shift_en(tx_clk_shift_en));
	rmcs_mac_model rmcs_mac_model_i (.rmii_clk(rmii_clk), .crs_dv(crs_dv), .rxd(rxd), .clr(clr),
		.rises(rises), .dibits(dibits));
	////////////////////////////////////////////////////////////////
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task final_report;
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge sys_clk) reg_wr = 0;
	endtask : wr
	task rdc(input logic [4:0] a, input logic [15:0] e);
		@(negedge sys_clk) {reg_rd, reg_addr} = {1'b1, a};
		@(negedge sys_clk) reg_rd = 0;
		check("reg_rdata", reg_rdata, e);
	endtask : rdc
	task do_reset(input logic strap);
		rst = 1;
		strap_master = strap;
		repeat (20) @(posedge rmii_clk);
		@(negedge sys_clk) rst = 0;
		repeat (3) @(negedge sys_clk);
	endtask : do_reset
	// Sends n all-ones dibits gap+1 cycles apart, carrier dropped gap+tail cycles after the last
	task send(input int n, input int gap, input int tail);
		@(negedge rmii_clk) clr = 1;
		@(negedge rmii_clk) clr = 0;
		@(negedge sys_clk) rx_carrier = 1;
		repeat (n) begin
			@(negedge sys_clk) rx_valid = 1;
			@(negedge sys_clk) rx_valid = 0;
			repeat (gap - 1) @(negedge sys_clk);
		end
		repeat (tail) @(negedge sys_clk);
		rx_carrier = 0;
		repeat (800) @(negedge sys_clk);
	endtask : send
	////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		mismatches++;
		final_report();
	end
	initial begin
		do_reset(1);
		rdc(`RMCS_CTL_OFF, 16'h000D);
		rdc(`RMCS_LED_OFF, 16'h0400);
		check("slave_mode", 16'(slave_mode), 16'h0000);
		check("ref_clk_50m_sel", 16'(ref_clk_50m_sel), 16'h0000);
		wr(5'h00, 16'hFFFF);
		rdc(5'h00, 16'h0000);
		foreach (pk[i]) begin
			wr(`RMCS_CTL_OFF, 16'(pk[i]));
			send(8, 19, 0);
			check("rx dibits", 16'(dibits), 16'h0008);
			check("crs_dv rises", pk[i][4] ? 16'(rises) : 16'(rises > 1), 16'h0001);
			rdc(`RMCS_CTL_OFF, 16'h000C | 16'(pk[i]));
		end
		// Dibits every second sys cycle overrun the 16-entry buffer
		send(24, 1, 0);
		rdc(`RMCS_CTL_OFF, 16'h0004);
		rdc(`RMCS_CTL_OFF, 16'h000C);
		wr(`RMCS_CTL_OFF, 16'h0011);
		send(2, 19, 200);
		rdc(`RMCS_CTL_OFF, 16'h0019);
		rdc(`RMCS_CTL_OFF, 16'h001D);
		wr(`RMCS_CTL_OFF, 16'hFFFF);
		rdc(`RMCS_CTL_OFF, 16'h019F);
		check("tx_clk_shift_en", 16'(tx_clk_shift_en), 16'h0000);
		check("ref_clk_50m_sel", 16'(ref_clk_50m_sel), 16'h0001);
		wr(`RMCS_LED_OFF, 16'hFFFF);
		rdc(`RMCS_LED_OFF, 16'h0692);
		do_reset(0);
		rdc(`RMCS_CTL_OFF, 16'h008D);
		check("slave_mode", 16'(slave_mode), 16'h0001);
		wr(`RMCS_CTL_OFF, 16'h0101);
		repeat (4) @(negedge sys_clk);
		check("tx_clk_shift_en", 16'(tx_clk_shift_en), 16'h0001);
		check("ref_clk_50m_sel", 16'(ref_clk_50m_sel), 16'h0000);
		wr(`RMCS_CTL_OFF, 16'h0001);
		repeat (4) @(negedge sys_clk);
		check("tx_clk_shift_en", 16'(tx_clk_shift_en), 16'h0000);
		final_report();
	end
endmodule : test_rmii_config_status_regs

`default_nettype wire
